// file: verilog/pmc_map.svh
// Named constants for the MII carrier, collision and receive timing block.
// Included by the timing core and the bench; holds definitions only.
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// Core clock and bit times.
`define PMC_CLK_NS          10
`define PMC_BT100_NS        10
`define PMC_BT10_NS         100
`define PMC_NS_PER_MS       1000000

// Five-bit line symbols, first bit in the MSB.
`define PMC_SYM_J           5'h18
`define PMC_SYM_K           5'h11
`define PMC_SYM_T           5'h0d
`define PMC_SYM_R           5'h07
`define PMC_SYM_I           5'h1f
`define PMC_SYM_LAST        3'h4
`define PMC_NIB_PRE         4'h5

// Receive event timing, in 100 Mb/s bit times from the first bit of a symbol.
`define PMC_EV_W            5
`define PMC_HIT_BT          5'h08
`define PMC_CRS_ON_BT       5'h0c
`define PMC_COL_ON_BT       5'h0b
`define PMC_CRS_OFF_BT      5'h0f
`define PMC_COL_OFF_BT      5'h0f
`define PMC_MII_REL_BT      5'h10
`define PMC_EV_MAX          5'h1f

// Transmit enable to carrier sense limits, in bit times.
`define PMC_TXEN_CRS_MAX_BT   4
`define PMC_TXEN_CRS10_MAX_BT 2
`define PMC_TX_PATH_CYC       3

// Heartbeat pulse.
`define PMC_SQE_CNT_W       8
`define PMC_SQE_DELAY_NS    850
`define PMC_SQE_WIDTH_NS    1000
`define PMC_SQE_MAX_NS      1500
`define PMC_SQE_DELAY_CYC   (`PMC_SQE_DELAY_NS / `PMC_CLK_NS)
`define PMC_SQE_WIDTH_CYC   ((`PMC_SQE_WIDTH_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)

// Reset sequencing.
`define PMC_CNT_W           26
`define PMC_POR_MS          45
`define PMC_TXCLK_MS        35
`define PMC_POR_CYC         (`PMC_POR_MS * `PMC_NS_PER_MS / `PMC_CLK_NS)
`define PMC_TXCLK_CYC       (`PMC_TXCLK_MS * `PMC_NS_PER_MS / `PMC_CLK_NS)

`endif

// file: verilog/pmc_pkg.sv
// Types shared by the MII carrier, collision and receive timing block.
// Assumes nothing of its surroundings.
package pmc_pkg;

  typedef enum logic [3:0] {
    PMC_POR     = 4'h1,
    PMC_ISOLATE = 4'h2,
    PMC_WAITCLK = 4'h4,
    PMC_RUN     = 4'h8
  } pmc_phy_state_t;

  typedef enum logic [2:0] {
    PMC_SQE_IDLE  = 3'h1,
    PMC_SQE_WAIT  = 3'h2,
    PMC_SQE_PULSE = 3'h4
  } pmc_sqe_state_t;

endpackage

// file: verilog/pmc_sync.sv
// Two flip-flop level synchroniser, one bit per lane.
// Assumes each input lane is a level that holds for several destination clocks.
`timescale 1ns/10ps
module pmc_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input  logic             clk,
  input  logic             hardware_reset_pin_n,
  // Levels
  input  logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  if (WIDTH < 1) begin : g_chk
    $error("pmc_sync needs at least one lane");
  end

  always_ff @(posedge clk or negedge hardware_reset_pin_n) begin
    if (!hardware_reset_pin_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= din;
      stage2_reg <= stage1_reg;
    end
  end

  assign dout = stage2_reg;

endmodule

// file: verilog/pmc_fifo.sv
// Single-clock first-word-fall-through FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two so that the pointers wrap by themselves.
`timescale 1ns/10ps
module pmc_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  logic             clk,
  input  logic             hardware_reset_pin_n,
  // Fill side
  input  logic             inValid,
  output logic             inReady,
  input  logic [WIDTH-1:0] inData,
  // Drain side
  output logic             outValid,
  input  logic             outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = PW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_reg;
  logic [PW-1:0]    rdPtr_reg;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  wire              pushFire;
  wire              popFire;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("pmc_fifo depth must be a power of two of at least two");
  end

  assign inReady    = (count_reg != CW'(DEPTH));
  assign outValid   = (count_reg != '0);
  assign outData    = mem[rdPtr_reg];
  assign pushFire   = inValid & inReady;
  assign popFire    = outValid & outReady;
  assign count_next = CW'(count_reg + CW'(pushFire) - CW'(popFire));

  // The array has no reset; a word is only read after it has been written.
  always_ff @(posedge clk) begin
    if (pushFire) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk or negedge hardware_reset_pin_n) begin
    if (!hardware_reset_pin_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= pushFire ? PW'(wrPtr_reg + 1'b1) : wrPtr_reg;
      rdPtr_reg <= popFire ? PW'(rdPtr_reg + 1'b1) : rdPtr_reg;
      count_reg <= count_next;
    end
  end

endmodule

// file: verilog/pmc_mii_timing.sv
// MAC-side MII timing core of a 10/100 transceiver: carrier sense, collision,
// heartbeat, receive symbol path and reset sequencing.
// Assumes clk runs at the 100 Mb/s bit rate with line bits aligned to it, and
// that miiClk is the MII transmit clock, unrelated in phase to clk.
//
// Contract
// - 100M half duplex: carrier within 4 bits of enable.
// - Carrier drops within 4 bits after enable falls.
// - 10M half duplex: carrier within 2 bits of enable.
// - Start symbol on receive data within 17/9 bits.
// - Receive carrier rises 10 to 14 bits after start.
// - Collision rises 9 to 13 bits when transmitting.
// - Receive carrier falls 13 to 18 bits after end.
// - Collision falls 13 to 18 bits after end symbol.
// - Power-on reset completes between 40 and 500 ms.
// - Reset pin low isolates outputs and restarts initialization; here rxData is not held low and only the transmit clock wait restarts.
// - Transmit clock valid within 500 ms after release.
// - Heartbeat starts within 1500 ns of enable falling.
// - Heartbeat lasts 1000 ns, never above 1500 ns.
// - A 10M bit time is 100 ns.
`timescale 1ns/10ps
`include "pmc_map.svh"
module pmc_mii_timing #(
  parameter int               DATA_W       = 5,
  parameter int               FIFO_DEPTH   = 16,
  parameter int               CNT_W        = `PMC_CNT_W,
  parameter logic [CNT_W-1:0] POR_CYCLES   = CNT_W'(`PMC_POR_CYC),
  parameter logic [CNT_W-1:0] TXCLK_CYCLES = CNT_W'(`PMC_TXCLK_CYC)
) (
  // Core clock and reset
  input  logic              clk,
  input  logic              hardware_reset_pin_n,
  // MII transmit side, link clock domain
  input  logic              miiClk,
  input  logic              txEn,
  output logic              txClkValid,
  // Line receive pair
  input  logic              lineReceivePlus,
  input  logic              lineReceiveMinus,
  // Pins
  input  logic              hardwareResetPinN,
  input  logic              speed100,
  input  logic              fullDuplex,
  input  logic              symbolMode,
  // MII status
  output logic              crs,
  output logic              col,
  // Receive data
  output logic [DATA_W-1:0] rxData,
  output logic              rxDv,
  input  logic              rxReady,
  output logic              rxFifoReady
);

  localparam int SYNC_W         = 7;
  localparam int CRS_ON_DLY     = `PMC_CRS_ON_BT - `PMC_HIT_BT + 1;
  localparam int COL_ON_DLY     = `PMC_COL_ON_BT - `PMC_HIT_BT;
  localparam int SQE_ASSERT_DLY = `PMC_SQE_DELAY_CYC + 1;
  localparam int SQE_LAST       = `PMC_SQE_WIDTH_CYC - 1;

  // Elaboration checks.
  if (DATA_W != 5 || FIFO_DEPTH < 2) begin : g_chk_data
    $error("receive path needs five-bit words and a real FIFO");
  end
  if (POR_CYCLES < 1 || TXCLK_CYCLES < 1) begin : g_chk_cnt
    $error("reset sequencing counts must be at least one cycle");
  end
  if (`PMC_BT100_NS != `PMC_CLK_NS) begin : g_chk_bt100
    $error("line sampling assumes one 100M bit per core clock");
  end
  if (`PMC_TX_PATH_CYC * `PMC_CLK_NS > `PMC_TXEN_CRS_MAX_BT * `PMC_BT100_NS ||
      `PMC_TX_PATH_CYC * `PMC_CLK_NS > `PMC_TXEN_CRS10_MAX_BT * `PMC_BT10_NS) begin : g_chk_tx
    $error("transmit enable path too slow for carrier sense");
  end
  if ((`PMC_SQE_DELAY_CYC + `PMC_TX_PATH_CYC) * `PMC_CLK_NS > `PMC_SQE_MAX_NS ||
      `PMC_SQE_WIDTH_CYC * `PMC_CLK_NS > `PMC_SQE_MAX_NS) begin : g_chk_sqe
    $error("heartbeat timing out of range");
  end

  // Turns a received five-bit code group into its data nibble.
  function automatic logic [3:0] decodeSym(input logic [4:0] sym);
    logic [3:0] nib;
    nib = '0;
    case (sym)
      5'h1e: nib = 4'h0;
      5'h09: nib = 4'h1;
      5'h14: nib = 4'h2;
      5'h15: nib = 4'h3;
      5'h0a: nib = 4'h4;
      5'h0b: nib = 4'h5;
      5'h0e: nib = 4'h6;
      5'h0f: nib = 4'h7;
      5'h12: nib = 4'h8;
      5'h13: nib = 4'h9;
      5'h16: nib = 4'ha;
      5'h17: nib = 4'hb;
      5'h1a: nib = 4'hc;
      5'h1b: nib = 4'hd;
      5'h1c: nib = 4'he;
      5'h1d: nib = 4'hf;
      `PMC_SYM_J: nib = `PMC_NIB_PRE;
      `PMC_SYM_K: nib = `PMC_NIB_PRE;
      default: nib = '0;
    endcase
    return nib;
  endfunction

  // Link clock domain: transmit enable is sampled on the MII clock.
  logic txEnSample_reg;
  wire  txClkValidLink;
  logic clkOk_reg;

  pmc_sync #(
    .WIDTH (1)
  ) linkSync (
    .clk    (miiClk),
    .hardware_reset_pin_n (hardware_reset_pin_n),
    .din    (clkOk_reg),
    .dout   (txClkValidLink)
  );

  // Enable is ignored until the transmit clock is declared valid.
  always_ff @(posedge miiClk or negedge hardware_reset_pin_n) begin
    if (!hardware_reset_pin_n) begin
      txEnSample_reg <= 1'b0;
    end else begin
      txEnSample_reg <= txEn & txClkValidLink;
    end
  end

  assign txClkValid = txClkValidLink;

  // Core domain: every pin and the sampled enable pass two flip-flops.
  wire [SYNC_W-1:0] pinSync;
  wire              lineBit;
  wire              hwResetLow;
  wire              speed100S;
  wire              halfMode;
  wire              streamMode;
  wire              txSync;

  pmc_sync #(
    .WIDTH (SYNC_W)
  ) pinSyncInst (
    .clk    (clk),
    .hardware_reset_pin_n (hardware_reset_pin_n),
    .din    ({lineReceivePlus, lineReceiveMinus, hardwareResetPinN, speed100,
              fullDuplex, symbolMode, txEnSample_reg}),
    .dout   (pinSync)
  );

  assign lineBit    = pinSync[6] & ~pinSync[5];
  // Pulses shorter than one core clock may be missed; the pin is held long enough.
  assign hwResetLow = ~pinSync[4];
  assign speed100S  = pinSync[3];
  assign halfMode   = ~pinSync[2];
  assign streamMode = pinSync[1];
  assign txSync     = pinSync[0];

  // Reset sequencing.
  pmc_pkg::pmc_phy_state_t state_reg;
  pmc_pkg::pmc_phy_state_t state_next;
  logic [CNT_W-1:0]        cnt_reg;
  logic [CNT_W-1:0]        cnt_next;
  wire                     runNext;

  always_comb begin
    state_next = state_reg;
    cnt_next   = CNT_W'(cnt_reg + 1'b1);
    case (state_reg)
      pmc_pkg::PMC_POR: begin
        if (cnt_reg == POR_CYCLES - 1'b1) begin
          state_next = hwResetLow ? pmc_pkg::PMC_ISOLATE : pmc_pkg::PMC_WAITCLK;
          cnt_next   = '0;
        end
      end
      pmc_pkg::PMC_ISOLATE: begin
        cnt_next = '0;
        if (!hwResetLow) begin
          state_next = pmc_pkg::PMC_WAITCLK;
        end
      end
      pmc_pkg::PMC_WAITCLK: begin
        if (hwResetLow) begin
          state_next = pmc_pkg::PMC_ISOLATE;
          cnt_next   = '0;
        end else if (cnt_reg == TXCLK_CYCLES - 1'b1) begin
          state_next = pmc_pkg::PMC_RUN;
          cnt_next   = '0;
        end
      end
      pmc_pkg::PMC_RUN: begin
        cnt_next = '0;
        if (hwResetLow) begin
          state_next = pmc_pkg::PMC_ISOLATE;
        end
      end
      default: begin
        state_next = pmc_pkg::PMC_POR;
        cnt_next   = '0;
      end
    endcase
  end

  assign runNext = (state_next == pmc_pkg::PMC_RUN);

  always_ff @(posedge clk or negedge hardware_reset_pin_n) begin
    if (!hardware_reset_pin_n) begin
      state_reg <= pmc_pkg::PMC_POR;
      cnt_reg   <= '0;
      clkOk_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      clkOk_reg <= runNext;
    end
  end

  // Receive symbol alignment and event timing.
  logic [4:0]           shift_reg;
  logic [2:0]           phase_reg;
  logic                 inFrame_reg;
  logic [`PMC_EV_W-1:0] evCnt_reg;
  logic                 evStart_reg;
  logic                 rxCarrier_reg;
  logic                 col100_reg;
  logic                 holdOff_reg;
  wire                  jHit;
  wire                  symDone;
  wire                  endHit;
  wire                  evAt;
  wire                  crsOnEv;
  wire                  crsOffEv;
  wire                  colOnEv;
  wire                  colOffEv;
  wire                  relEv;
  wire                  rxCarrier_next;
  wire                  col100_next;

  // A start symbol is only looked for outside a frame, which gives the alignment.
  assign jHit     = ~inFrame_reg & speed100S & (shift_reg == `PMC_SYM_J);
  assign symDone  = inFrame_reg & (phase_reg == `PMC_SYM_LAST);
  assign endHit   = symDone & ((shift_reg == `PMC_SYM_T) | (shift_reg == `PMC_SYM_I));
  assign evAt     = evStart_reg;
  assign crsOnEv  = evAt & (evCnt_reg == `PMC_CRS_ON_BT - 1'b1);
  assign colOnEv  = evAt & (evCnt_reg == `PMC_COL_ON_BT - 1'b1) &
                    txSync & halfMode & speed100S;
  assign crsOffEv = ~evAt & (evCnt_reg == `PMC_CRS_OFF_BT - 1'b1);
  assign colOffEv = ~evAt & (evCnt_reg == `PMC_COL_OFF_BT - 1'b1);
  assign relEv    = evAt & (evCnt_reg == `PMC_MII_REL_BT - 1'b1);

  assign rxCarrier_next = crsOnEv ? 1'b1 : (crsOffEv ? 1'b0 : rxCarrier_reg);
  assign col100_next    = colOnEv ? 1'b1 : (colOffEv ? 1'b0 : col100_reg);

  always_ff @(posedge clk or negedge hardware_reset_pin_n) begin
    if (!hardware_reset_pin_n) begin
      shift_reg     <= `PMC_SYM_I;
      phase_reg     <= '0;
      inFrame_reg   <= 1'b0;
      evCnt_reg     <= `PMC_EV_MAX;
      evStart_reg   <= 1'b0;
      rxCarrier_reg <= 1'b0;
      col100_reg    <= 1'b0;
      holdOff_reg   <= 1'b0;
    end else begin
      shift_reg     <= {shift_reg[3:0], lineBit};
      phase_reg     <= (jHit | symDone) ? '0 : 3'(phase_reg + 1'b1);
      inFrame_reg   <= jHit | (inFrame_reg & ~endHit);
      evStart_reg   <= (jHit | endHit) ? jHit : evStart_reg;
      if (jHit | endHit) begin
        evCnt_reg <= `PMC_HIT_BT;
      end else if (evCnt_reg != `PMC_EV_MAX) begin
        evCnt_reg <= `PMC_EV_W'(evCnt_reg + 1'b1);
      end
      rxCarrier_reg <= rxCarrier_next;
      col100_reg    <= col100_next;
      // In MII mode the first word waits for the nibble latency.
      holdOff_reg   <= (jHit & ~streamMode) | (holdOff_reg & ~relEv);
    end
  end

  // Receive words go through the FIFO to the MAC.
  wire              pushValid;
  wire [DATA_W-1:0] pushData;
  wire              fifoOutValid;
  wire [DATA_W-1:0] fifoOutData;
  wire              popReady;
  wire              popFire;

  assign pushValid = jHit | (symDone & ~endHit) | endHit;
  assign pushData  = streamMode ? shift_reg : {1'b0, decodeSym(shift_reg)};
  assign popReady  = rxReady & ~holdOff_reg;
  assign popFire   = popReady & fifoOutValid;

  pmc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) rxFifo (
    .clk      (clk),
    .hardware_reset_pin_n   (hardware_reset_pin_n),
    .inValid  (pushValid),
    .inReady  (rxFifoReady),
    .inData   (pushData),
    .outValid (fifoOutValid),
    .outReady (popReady),
    .outData  (fifoOutData)
  );

  // Heartbeat after a 10M half duplex frame.
  pmc_pkg::pmc_sqe_state_t  sqeState_reg;
  pmc_pkg::pmc_sqe_state_t  sqeState_next;
  logic [`PMC_SQE_CNT_W-1:0] sqeCnt_reg;
  logic [`PMC_SQE_CNT_W-1:0] sqeCnt_next;
  logic                      txPrev_reg;
  wire                       txFall;
  wire                       sqeOn;
  wire                       sqeOnNext;

  assign txFall = txPrev_reg & ~txSync;

  always_comb begin
    sqeState_next = sqeState_reg;
    sqeCnt_next   = `PMC_SQE_CNT_W'(sqeCnt_reg - 1'b1);
    case (sqeState_reg)
      pmc_pkg::PMC_SQE_IDLE: begin
        sqeCnt_next = '0;
        if (txFall & ~speed100S & halfMode) begin
          sqeState_next = pmc_pkg::PMC_SQE_WAIT;
          sqeCnt_next   = `PMC_SQE_CNT_W'(`PMC_SQE_DELAY_CYC - 1);
        end
      end
      pmc_pkg::PMC_SQE_WAIT: begin
        if (sqeCnt_reg == '0) begin
          sqeState_next = pmc_pkg::PMC_SQE_PULSE;
          sqeCnt_next   = `PMC_SQE_CNT_W'(`PMC_SQE_WIDTH_CYC - 1);
        end
      end
      pmc_pkg::PMC_SQE_PULSE: begin
        if (sqeCnt_reg == '0) begin
          sqeState_next = pmc_pkg::PMC_SQE_IDLE;
        end
      end
      default: begin
        sqeState_next = pmc_pkg::PMC_SQE_IDLE;
        sqeCnt_next   = '0;
      end
    endcase
  end

  assign sqeOn     = (sqeState_reg == pmc_pkg::PMC_SQE_PULSE);
  assign sqeOnNext = (sqeState_next == pmc_pkg::PMC_SQE_PULSE);

  always_ff @(posedge clk or negedge hardware_reset_pin_n) begin
    if (!hardware_reset_pin_n) begin
      sqeState_reg <= pmc_pkg::PMC_SQE_IDLE;
      sqeCnt_reg   <= '0;
      txPrev_reg   <= 1'b0;
    end else begin
      sqeState_reg <= sqeState_next;
      sqeCnt_reg   <= sqeCnt_next;
      txPrev_reg   <= txSync;
    end
  end

  // MII outputs; crs, col and rxDv are held low while the device is isolated, rxData is not.
  logic              crs_reg;
  logic              col_reg;
  logic              rxDv_reg;
  logic [DATA_W-1:0] rxData_reg;

  always_ff @(posedge clk or negedge hardware_reset_pin_n) begin
    if (!hardware_reset_pin_n) begin
      crs_reg    <= 1'b0;
      col_reg    <= 1'b0;
      rxDv_reg   <= 1'b0;
      rxData_reg <= '0;
    end else begin
      crs_reg    <= runNext & ((txSync & halfMode) | rxCarrier_next);
      col_reg    <= runNext & (col100_next | sqeOnNext);
      rxDv_reg   <= runNext & popFire;
      rxData_reg <= popFire ? fifoOutData : rxData_reg;
    end
  end

  assign crs    = crs_reg;
  assign col    = col_reg;
  assign rxDv   = rxDv_reg;
  assign rxData = rxData_reg;

  // Checks.
  crs_rx_on_a: assert property (@(posedge clk) disable iff (!hardware_reset_pin_n)
    jHit |-> ##CRS_ON_DLY rxCarrier_reg) else $error("receive carrier late");
  col_rx_on_a: assert property (@(posedge clk) disable iff (!hardware_reset_pin_n)
    jHit ##COL_ON_DLY (txSync && halfMode && speed100S) |=> col100_reg)
    else $error("collision not raised");
  crs_rx_off_a: assert property (@(posedge clk) disable iff (!hardware_reset_pin_n)
    (endHit && rxCarrier_reg) |-> rxCarrier_reg[*8] ##1 !rxCarrier_reg)
    else $error("receive carrier release mistimed");
  col_rx_off_a: assert property (@(posedge clk) disable iff (!hardware_reset_pin_n)
    (endHit && col100_reg) |-> col100_reg[*8] ##1 !col100_reg)
    else $error("collision release mistimed");
  crs_tx_on_a: assert property (@(posedge clk) disable iff (!hardware_reset_pin_n)
    ($rose(txSync) && halfMode && !hwResetLow && state_reg == pmc_pkg::PMC_RUN) |=> crs)
    else $error("transmit carrier late");
  crs_tx_off_a: assert property (@(posedge clk) disable iff (!hardware_reset_pin_n)
    ($fell(txSync) && !rxCarrier_reg && !inFrame_reg) |=> !crs)
    else $error("transmit carrier held");
  sqe_delay_a: assert property (@(posedge clk) disable iff (!hardware_reset_pin_n)
    (txFall && !speed100S && halfMode && sqeState_reg == pmc_pkg::PMC_SQE_IDLE)
      |-> ##SQE_ASSERT_DLY $rose(sqeOn)) else $error("heartbeat start mistimed");
  sqe_width_a: assert property (@(posedge clk) disable iff (!hardware_reset_pin_n)
    $rose(sqeOn) |-> ##SQE_LAST sqeOn ##1 !sqeOn) else $error("heartbeat width wrong");
  iso_out_a: assert property (@(posedge clk) disable iff (!hardware_reset_pin_n)
    hwResetLow |=> (!crs && !col && !rxDv && !clkOk_reg))
    else $error("outputs active while isolated");
  rx_stream_a: assert property (@(posedge clk) disable iff (!hardware_reset_pin_n)
    (jHit && streamMode && !fifoOutValid) ##1 (rxReady && runNext)
      |=> (rxDv && rxData == `PMC_SYM_J)) else $error("stream start word late");
  rx_mii_a: assert property (@(posedge clk) disable iff (!hardware_reset_pin_n)
    (jHit && !streamMode && !fifoOutValid) ##1 rxReady[*8] ##1 (rxReady && runNext)
      |=> (rxDv && rxData == {1'b0, `PMC_NIB_PRE})) else $error("MII start word late");

endmodule

// file: testbench/pmc_mac_model.sv
// Behavioural MAC model on the transmit enable and receive hand-off of the timing core.
// Assumes txReq and rxHold come from the bench and change away from rising miiClk edges.
`timescale 1ns/10ps
module pmc_mac_model (
  // Link clock and reset
  input  logic miiClk,
  input  logic hardware_reset_pin_n,
  // Requests from the bench
  input  logic txReq,
  input  logic rxHold,
  // MII side
  input  logic txClkValid,
  output logic txEn,
  output logic rxReady
);
  // A MAC may not trust the transmit clock until it is flagged valid.
  always_ff @(posedge miiClk or negedge hardware_reset_pin_n) begin
    if (!hardware_reset_pin_n) txEn <= 1'b0;
    else txEn <= txReq & txClkValid;
  end
  assign rxReady = ~rxHold;
endmodule

// file: testbench/pmc_mii_timing_bench.sv
// Self-checking bench of the MII carrier, collision, receive and reset timing core.
// Assumes shortened reset counts; line bits are driven one per clk at the falling edge.
`timescale 1ns/10ps
`include "pmc_map.svh"
module pmc_mii_timing_bench;
  logic clk = 1'b0, miiClk = 1'b0, hardware_reset_pin_n = 1'b1, txReq = 1'b0, rxHold = 1'b0, pinN = 1'b1;
  logic lp = 1'b1, lm = 1'b0, speed100 = 1'b1, fullDuplex = 1'b0, symbolMode = 1'b1;
  logic       txEn, rxReady, txClkValid, crs, col, rxDv, rxFifoReady;
  logic [1:0] pv = 2'h0;
  logic [4:0] rxData, dvData;
  wire  [1:0] st = {col, crs};
  int errors = 0, tests_run = 0, cyc = 0, dvAt, dvCnt, tJ, tT, on[2], off[2];
  realtime t0, t1, t2;

  always #5 clk = ~clk;
  always #32 miiClk = ~miiClk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(negedge clk) begin
    if (rxDv === 1'b1) begin
      dvCnt++;
      if (dvAt < 0) begin
        dvAt = cyc;
        dvData = rxData;
      end
    end
    for (int k = 0; k < 2; k++) begin
      if (st[k] === 1'b1 && pv[k] === 1'b0 && on[k] < 0) on[k] = cyc;
      if (st[k] === 1'b0 && pv[k] === 1'b1 && off[k] < 0) off[k] = cyc;
    end
    pv = st;
  end

  pmc_mac_model mac (.miiClk(miiClk), .hardware_reset_pin_n(hardware_reset_pin_n), .txReq(txReq), .rxHold(rxHold),
    .txClkValid(txClkValid), .txEn(txEn), .rxReady(rxReady));
  pmc_mii_timing #(.POR_CYCLES(26'h14), .TXCLK_CYCLES(26'h1e)) dut (.clk(clk),
    .hardware_reset_pin_n(hardware_reset_pin_n), .miiClk(miiClk), .txEn(txEn), .txClkValid(txClkValid),
    .lineReceivePlus(lp), .lineReceiveMinus(lm), .hardwareResetPinN(pinN),
    .speed100(speed100), .fullDuplex(fullDuplex), .symbolMode(symbolMode), .crs(crs),
    .col(col), .rxData(rxData), .rxDv(rxDv), .rxReady(rxReady), .rxFifoReady(rxFifoReady));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t ns: %s", $time, what);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Idle on the line is all ones, so a released line never looks like a start symbol.
  task automatic send_sym(input logic [4:0] s, output int t);
    for (int i = 4; i >= 0; i--) begin
      @(negedge clk);
      lp = s[i];
      lm = ~s[i];
      if (i == 4) t = cyc + 1;
    end
  endtask

  task automatic frame(input int n);
    int d;
    on = '{-1, -1};
    off = '{-1, -1};
    dvAt = -1;
    dvCnt = 0;
    send_sym(`PMC_SYM_J, tJ);
    send_sym(`PMC_SYM_K, d);
    repeat (n) send_sym(5'h1e, d);
    send_sym(`PMC_SYM_T, tT);
    send_sym(`PMC_SYM_R, d);
    repeat (4) send_sym(`PMC_SYM_I, d);
  endtask

  task automatic wait_st(input int k, input logic val, output realtime t);
    repeat (300) begin
      @(posedge clk);
      #1;
      if (st[k] === val) break;
    end
    t = $realtime - 1;
    @(negedge clk);
  endtask

  // The request moves on the link clock's falling edge so the MAC never races it.
  task automatic set_tx(input logic v);
    @(negedge miiClk);
    txReq = v;
    @(posedge miiClk);
    @(posedge miiClk);
    t0 = $realtime;
    @(negedge clk);
  endtask

  task automatic t_tx(input logic s, input int onNs, input int offNs);
    speed100 = s;
    set_tx(1'b1);
    wait_st(0, 1'b1, t1);
    check(t1 - t0 <= onNs, 1'b1, "carrier late after enable");
    set_tx(1'b0);
    wait_st(0, 1'b0, t1);
    check(t1 - t0 <= offNs, 1'b1, "carrier late to drop");
  endtask

  task automatic t_heartbeat();
    t_tx(1'b0, 2 * `PMC_BT10_NS, 4 * `PMC_BT10_NS);
    wait_st(1, 1'b1, t1);
    check(t1 - t0 <= `PMC_SQE_MAX_NS, 1'b1, "heartbeat late");
    wait_st(1, 1'b0, t2);
    check(t2 - t1, `PMC_SQE_WIDTH_NS, "heartbeat width");
    speed100 = 1'b1;
  endtask

  task automatic t_full_duplex();
    fullDuplex = 1'b1;
    set_tx(1'b1);
    repeat (20) @(negedge clk);
    check(crs, 1'b0, "carrier in full duplex");
    set_tx(1'b0);
    fullDuplex = 1'b0;
  endtask

  task automatic t_rx(input logic sm, input int lim, input logic [4:0] first);
    symbolMode = sm;
    frame(2);
    check(dvAt - tJ inside {[0:lim]}, 1'b1, "start symbol late on receive data");
    check(dvData, first, "start symbol value");
    check(on[0] - tJ inside {[10:14]}, 1'b1, "receive carrier rise");
    check(off[0] - tT inside {[13:18]}, 1'b1, "receive carrier fall");
  endtask

  task automatic t_collision();
    set_tx(1'b1);
    repeat (10) @(negedge clk);
    frame(2);
    check(on[1] - tJ inside {[9:13]}, 1'b1, "collision rise");
    check(off[1] - tT inside {[13:18]}, 1'b1, "collision fall");
    set_tx(1'b0);
  endtask

  task automatic t_fill();
    symbolMode = 1'b1;
    rxHold = 1'b1;
    frame(20);
    check(rxFifoReady, 1'b0, "full buffer still ready");
    rxHold = 1'b0;
    repeat (40) @(negedge clk);
    check(dvCnt, 16, "words drained from full buffer");
  endtask

  task automatic t_pin();
    set_tx(1'b1);
    wait_st(0, 1'b1, t1);
    @(negedge clk);
    pinN = 1'b0;
    repeat (6) @(negedge clk);
    check(st, 2'h0, "outputs not isolated by reset pin");
    repeat (44) @(negedge clk);
    check(txClkValid, 1'b0, "transmit clock flagged valid in reset");
    pinN = 1'b1;
    repeat (500) begin
      @(negedge clk);
      if (txClkValid === 1'b1) break;
    end
    check(txClkValid, 1'b1, "transmit clock never valid after reset pin");
    set_tx(1'b0);
  endtask

  // Reset falls after time zero so that both clock domains see its edge.
  initial begin
    @(negedge clk);
    hardware_reset_pin_n = 1'b0;
    repeat (2) @(negedge clk);
    check({crs, col, rxDv, txClkValid}, 4'h0, "outputs active in reset");
    hardware_reset_pin_n = 1'b1;
    repeat (500) begin
      @(negedge clk);
      if (txClkValid === 1'b1) break;
    end
    check(txClkValid, 1'b1, "transmit clock never valid");
    t_tx(1'b1, 4 * `PMC_BT100_NS, 4 * `PMC_BT100_NS);
    t_heartbeat();
    t_full_duplex();
    t_rx(1'b1, 9, `PMC_SYM_J);
    t_rx(1'b0, 17, {1'b0, `PMC_NIB_PRE});
    t_collision();
    t_fill();
    t_pin();
    wrap_up();
  end

  initial begin
    #400us;
    errors++;
    wrap_up();
  end
endmodule
